// ===== logic/gbt_burst_dp.sv
// Read and write burst data path of an eight-bank graphics DRAM.
// Assumes CLK oversamples CK and the write strobe by a wide margin;
// latencies and burst order come from mode-register logic on CLK.
`timescale 1ns/1ps
module gbt_burst_dp
  import gbt_pkg::*;
#(
  parameter int LAT_DEPTH  = GBT_LAT_DEPTH,
  parameter int FIFO_DEPTH = GBT_FIFO_DEPTH
) (
  input  wire logic                  CLK,
  input  wire logic                  RESET,
  input  wire logic                  CK,
  input  wire logic                  CS_N,
  input  wire logic                  RAS_N,
  input  wire logic                  CAS_N,
  input  wire logic                  WE_N,
  input  wire logic [GBT_BANK_W-1:0] BA,
  input  wire logic [GBT_ADDR_W-1:0] ADDR,
  input  wire logic [GBT_DQ_W-1:0]   DQ_IN,
  output logic      [GBT_DQ_W-1:0]   DQ_OUT,
  output logic                       DQ_OE,
  input  wire logic                  WRITE_DATA_STROBE,
  output logic                       READ_DATA_STROBE,
  output logic                       READ_DATA_STROBE_OE,
  input  wire logic [GBT_LAT_W-1:0]  CAS_LATENCY,
  input  wire logic [GBT_LAT_W-1:0]  WRITE_LATENCY,
  input  wire logic                  BURST_INTERLEAVE,
  output logic                       ARR_RD_EN,
  output logic      [GBT_BANK_W-1:0] ARR_RD_BANK,
  output logic      [GBT_COL_W-1:0]  ARR_RD_COL,
  input  wire logic [GBT_DQ_W-1:0]   ARR_RD_DATA,
  output logic                       WR_VALID,
  input  wire logic                  WR_READY,
  output logic      [GBT_BANK_W-1:0] WR_BANK,
  output logic      [GBT_COL_W-1:0]  WR_COL,
  output logic      [GBT_DQ_W-1:0]   WR_DATA,
  output logic                       RD_AUTO_PRE,
  output logic      [GBT_BANK_W-1:0] RD_PRE_BANK,
  output logic                       WR_AUTO_PRE,
  output logic      [GBT_BANK_W-1:0] WR_PRE_BANK,
  output logic                       WR_DROP,
  output logic                       WR_REFUSED
);

  localparam int FW = GBT_BANK_W + GBT_COL_W + GBT_DQ_W;

  typedef struct packed {
    logic                                  ck_m;
    logic                                  ck_s;
    logic                                  ck_p;
    logic [GBT_CMD_W-1:0]                  cmd_m;
    logic [GBT_CMD_W-1:0]                  cmd_s;
    logic [GBT_BANK_W-1:0]                 ba_m;
    logic [GBT_BANK_W-1:0]                 ba_s;
    logic [GBT_ADDR_W-1:0]                 ad_m;
    logic [GBT_ADDR_W-1:0]                 ad_s;
    logic                                  wq_m;
    logic                                  wq_s;
    logic                                  wq_p;
    logic [GBT_DQ_W-1:0]                   dq_m;
    logic [GBT_DQ_W-1:0]                   dq_s;
    gbt_burst_t [LAT_DEPTH-1:0]            rline;
    gbt_burst_t [LAT_DEPTH-1:0]            wline;
    gbt_rd_ph_t                            rd_ph;
    gbt_burst_t                            rd_cur;
    gbt_burst_t                            rd_nxt;
    gbt_wr_st_t                            wr_st;
    logic [GBT_IDX_W-1:0]                  wr_cnt;
    gbt_burst_t                            wr_cur;
    gbt_burst_t                            wr_nxt;
    logic [GBT_DQ_W-1:0]                   dq_out;
    logic                                  dq_oe;
    logic                                  read_data_strobe;
    logic                                  read_data_strobe_oe;
    logic                                  rd_ap;
    logic [GBT_BANK_W-1:0]                 rd_ap_bank;
    logic                                  wr_ap;
    logic [GBT_BANK_W-1:0]                 wr_ap_bank;
    logic                                  wr_drop;
    logic                                  wr_refused;
  } gbt_st_t;

  gbt_st_t s_r;
  gbt_st_t s_nxt;

  logic          push;
  logic [FW-1:0] push_data;
  logic          fifo_in_ready;
  logic [FW-1:0] fifo_out_data;

  gbt_fifo #(
    .W     (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .clk       (CLK),
    .rst       (RESET),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (push_data),
    .out_valid (WR_VALID),
    .out_ready (WR_READY),
    .out_data  (fifo_out_data)
  );

  assign WR_BANK = fifo_out_data[FW-1 -: GBT_BANK_W];
  assign WR_COL  = fifo_out_data[GBT_DQ_W +: GBT_COL_W];
  assign WR_DATA = fifo_out_data[GBT_DQ_W-1:0];

  always_comb begin
    gbt_cmd_t             cmd;
    gbt_burst_t           ent;
    gbt_burst_t           rhead;
    gbt_burst_t           warm;
    logic                 ck_rise;
    logic                 ck_fall;
    logic                 wq_edge;
    logic [GBT_LAT_W-1:0] rd_idx;
    logic [GBT_LAT_W-1:0] wr_idx;
    logic [GBT_IDX_W-1:0] el;
    s_nxt       = s_r;
    el          = '0;
    push        = 1'b0;
    push_data   = '0;
    ARR_RD_EN   = 1'b0;
    ARR_RD_BANK = '0;
    ARR_RD_COL  = '0;
    // Pin synchronisers, two stages each
    s_nxt.ck_m  = CK;
    s_nxt.ck_s  = s_r.ck_m;
    s_nxt.ck_p  = s_r.ck_s;
    s_nxt.cmd_m = {CS_N, RAS_N, CAS_N, WE_N};
    s_nxt.cmd_s = s_r.cmd_m;
    s_nxt.ba_m  = BA;
    s_nxt.ba_s  = s_r.ba_m;
    s_nxt.ad_m  = ADDR;
    s_nxt.ad_s  = s_r.ad_m;
    s_nxt.wq_m  = WRITE_DATA_STROBE;
    s_nxt.wq_s  = s_r.wq_m;
    s_nxt.wq_p  = s_r.wq_s;
    s_nxt.dq_m  = DQ_IN;
    s_nxt.dq_s  = s_r.dq_m;
    s_nxt.rd_ap      = 1'b0;
    s_nxt.wr_ap      = 1'b0;
    s_nxt.wr_drop    = 1'b0;
    s_nxt.wr_refused = 1'b0;
    ck_rise = s_r.ck_s && !s_r.ck_p;
    ck_fall = !s_r.ck_s && s_r.ck_p;
    wq_edge = s_r.wq_s != s_r.wq_p;
    cmd     = gbt_decode(s_r.cmd_s);
    ent.vld  = 1'b1;
    ent.ap   = s_r.ad_s[GBT_AUTO_PRE_BIT];
    ent.bank = s_r.ba_s;
    ent.col  = s_r.ad_s[GBT_COL_W-1:0];
    rhead    = s_r.rline[0];
    warm     = s_r.wline[0];
    // Preamble starts one clock before the latency expires
    rd_idx = (CAS_LATENCY > GBT_RD_MIN_LAT) ? CAS_LATENCY - GBT_RD_MIN_LAT : '0;
    wr_idx = WRITE_LATENCY - GBT_WR_MIN_LAT;

    // Write strobe capture runs on strobe edges only
    if (wq_edge) begin
      case (s_r.wr_st)
        GBT_WR_WAIT_FALL: begin
          if (!s_r.wq_s) begin
            s_nxt.wr_st  = GBT_WR_CAP;
            s_nxt.wr_cnt = '0;
          end
        end
        GBT_WR_CAP: begin
          // Even elements on rising, odd on falling edges
          if (s_r.wq_s != s_r.wr_cnt[0]) begin
            push      = 1'b1;
            push_data = {s_r.wr_cur.bank,
                         gbt_burst_col(s_r.wr_cur.col, s_r.wr_cnt, BURST_INTERLEAVE),
                         s_r.dq_s};
            s_nxt.wr_drop = !fifo_in_ready;
            s_nxt.wr_cnt  = s_r.wr_cnt + 1'b1;
            if (s_r.wr_cnt == GBT_LAST_IDX) begin
              s_nxt.wr_ap      = s_r.wr_cur.ap;
              s_nxt.wr_ap_bank = s_r.wr_cur.bank;
              if (s_r.wr_nxt.vld) begin
                // Seamless strobe, next rise is data
                s_nxt.wr_cur = s_r.wr_nxt;
                s_nxt.wr_nxt = '0;
                s_nxt.wr_cnt = '0;
              end else begin
                s_nxt.wr_st  = GBT_WR_IDLE;
                s_nxt.wr_cur = '0;
              end
            end
          end
        end
        default: begin
          s_nxt.wr_st = GBT_WR_IDLE;
        end
      endcase
    end

    if (ck_rise) begin
      for (int i = 0; i < LAT_DEPTH - 1; i++) begin
        s_nxt.rline[i] = s_r.rline[i+1];
        s_nxt.wline[i] = s_r.wline[i+1];
      end
      s_nxt.rline[LAT_DEPTH-1] = '0;
      s_nxt.wline[LAT_DEPTH-1] = '0;
      if (cmd == GBT_CMD_READ) begin
        s_nxt.rline[rd_idx] = ent;
      end else if (cmd == GBT_CMD_WRITE) begin
        if (!fifo_in_ready) begin
          s_nxt.wr_refused = 1'b1;
        end else if (WRITE_LATENCY < GBT_WR_MIN_LAT) begin
          warm = ent;
        end else begin
          s_nxt.wline[wr_idx] = ent;
        end
      end
      // Precharge leaves bursts in flight untouched

      if (warm.vld) begin
        if (s_nxt.wr_st == GBT_WR_IDLE) begin
          s_nxt.wr_st  = GBT_WR_WAIT_FALL;
          s_nxt.wr_cur = warm;
        end else begin
          s_nxt.wr_nxt = warm;
        end
      end

      case (s_r.rd_ph)
        GBT_RD_IDLE: begin
          if (rhead.vld) begin
            s_nxt.rd_ph  = GBT_RD_PRE_HI;
            s_nxt.rd_cur = rhead;
          end
        end
        GBT_RD_PRE_LO: begin
          s_nxt.rd_ph = GBT_RD_E0;
        end
        GBT_RD_E1: begin
          s_nxt.rd_ph = GBT_RD_E2;
          if (rhead.vld) begin
            s_nxt.rd_nxt = rhead;
          end
        end
        GBT_RD_E3: begin
          s_nxt.rd_ap      = s_r.rd_cur.ap;
          s_nxt.rd_ap_bank = s_r.rd_cur.bank;
          if (s_r.rd_nxt.vld) begin
            s_nxt.rd_ph  = GBT_RD_E0;
            s_nxt.rd_cur = s_r.rd_nxt;
            s_nxt.rd_nxt = '0;
          end else if (rhead.vld) begin
            s_nxt.rd_ph  = GBT_RD_PRE_HI;
            s_nxt.rd_cur = rhead;
          end else begin
            s_nxt.rd_ph = GBT_RD_POST;
          end
        end
        default: begin
          s_nxt.rd_ph = s_r.rd_ph;
        end
      endcase
    end else if (ck_fall) begin
      case (s_r.rd_ph)
        GBT_RD_PRE_HI: s_nxt.rd_ph = GBT_RD_PRE_LO;
        GBT_RD_E0:     s_nxt.rd_ph = GBT_RD_E1;
        GBT_RD_E2:     s_nxt.rd_ph = GBT_RD_E3;
        GBT_RD_POST:   s_nxt.rd_ph = GBT_RD_IDLE;
        default:       s_nxt.rd_ph = s_r.rd_ph;
      endcase
    end

    // Fetch an element as its half cycle begins
    if ((s_nxt.rd_ph != s_r.rd_ph) && (s_nxt.rd_ph >= GBT_RD_E0) && (s_nxt.rd_ph <= GBT_RD_E3)) begin
      el           = GBT_IDX_W'(s_nxt.rd_ph - GBT_RD_E0);
      ARR_RD_EN    = 1'b1;
      ARR_RD_BANK  = s_nxt.rd_cur.bank;
      ARR_RD_COL   = gbt_burst_col(s_nxt.rd_cur.col, el, BURST_INTERLEAVE);
      s_nxt.dq_out = ARR_RD_DATA;
    end

    s_nxt.read_data_strobe_oe = s_nxt.rd_ph != GBT_RD_IDLE;
    s_nxt.read_data_strobe    = (s_nxt.rd_ph == GBT_RD_PRE_HI) || (s_nxt.rd_ph == GBT_RD_E0) ||
                    (s_nxt.rd_ph == GBT_RD_E2) || (s_nxt.rd_ph == GBT_RD_POST);
    s_nxt.dq_oe   = (s_nxt.rd_ph >= GBT_RD_E0) && (s_nxt.rd_ph <= GBT_RD_E3);
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign DQ_OUT              = s_r.dq_out;
  assign DQ_OE               = s_r.dq_oe;
  assign READ_DATA_STROBE    = s_r.read_data_strobe;
  assign READ_DATA_STROBE_OE = s_r.read_data_strobe_oe;
  assign RD_AUTO_PRE         = s_r.rd_ap;
  assign RD_PRE_BANK         = s_r.rd_ap_bank;
  assign WR_AUTO_PRE         = s_r.wr_ap;
  assign WR_PRE_BANK         = s_r.wr_ap_bank;
  assign WR_DROP             = s_r.wr_drop;
  assign WR_REFUSED          = s_r.wr_refused;

endmodule : gbt_burst_dp

// ===== logic/gbt_pkg.sv
// Shared constants, types and helpers of the graphics DRAM burst data path.
// Assumes one system clock that oversamples the memory clock and strobes.
package gbt_pkg;

  localparam int GBT_DQ_W         = 32;
  localparam int GBT_BANK_W       = 3;
  localparam int GBT_COL_W        = 8;
  localparam int GBT_ADDR_W       = 9;
  localparam int GBT_AUTO_PRE_BIT = 8;
  localparam int GBT_BURST_LEN    = 4;
  localparam int GBT_IDX_W        = 2;
  localparam int GBT_LAT_W        = 4;
  localparam int GBT_LAT_DEPTH    = 16;
  localparam int GBT_FIFO_DEPTH   = 32;
  localparam int GBT_CMD_W        = 4;
  localparam logic [GBT_IDX_W-1:0] GBT_LAST_IDX = 2'h3;
  localparam logic [GBT_LAT_W-1:0] GBT_RD_MIN_LAT = 4'h2;
  localparam logic [GBT_LAT_W-1:0] GBT_WR_MIN_LAT = 4'h2;

  typedef enum logic [2:0] {
    GBT_CMD_NOP,
    GBT_CMD_ACTIVATE,
    GBT_CMD_READ,
    GBT_CMD_WRITE,
    GBT_CMD_PRECHARGE,
    GBT_CMD_OTHER
  } gbt_cmd_t;

  typedef enum logic [2:0] {
    GBT_RD_IDLE,
    GBT_RD_PRE_HI,
    GBT_RD_PRE_LO,
    GBT_RD_E0,
    GBT_RD_E1,
    GBT_RD_E2,
    GBT_RD_E3,
    GBT_RD_POST
  } gbt_rd_ph_t;

  typedef enum logic [1:0] {
    GBT_WR_IDLE,
    GBT_WR_WAIT_FALL,
    GBT_WR_CAP
  } gbt_wr_st_t;

  typedef struct packed {
    logic                  vld;
    logic                  ap;
    logic [GBT_BANK_W-1:0] bank;
    logic [GBT_COL_W-1:0]  col;
  } gbt_burst_t;

  // Pins ordered {cs_n, ras_n, cas_n, we_n}
  function automatic gbt_cmd_t gbt_decode(input logic [GBT_CMD_W-1:0] c);
    gbt_cmd_t r;
    r = GBT_CMD_OTHER;
    if (c[3]) begin
      r = GBT_CMD_NOP;
    end else if (c == 4'h7) begin
      r = GBT_CMD_NOP;
    end else if (c == 4'h3) begin
      r = GBT_CMD_ACTIVATE;
    end else if (c == 4'h5) begin
      r = GBT_CMD_READ;
    end else if (c == 4'h4) begin
      r = GBT_CMD_WRITE;
    end else if (c == 4'h2) begin
      r = GBT_CMD_PRECHARGE;
    end
    return r;
  endfunction : gbt_decode

  // Column of element idx within a burst of four
  function automatic logic [GBT_COL_W-1:0] gbt_burst_col(input logic [GBT_COL_W-1:0] col,
                                                         input logic [GBT_IDX_W-1:0] idx,
                                                         input logic                 ilv);
    logic [GBT_IDX_W-1:0] lo;
    lo = ilv ? (col[GBT_IDX_W-1:0] ^ idx) : GBT_IDX_W'(col[GBT_IDX_W-1:0] + idx);
    return {col[GBT_COL_W-1:GBT_IDX_W], lo};
  endfunction : gbt_burst_col

endpackage : gbt_pkg

// ===== logic/gbt_fifo.sv
// Word FIFO with valid/ready on both sides, storage in flip-flops.
// Assumes DEPTH is a power of two; synchronous active-high reset.
`timescale 1ns/1ps
module gbt_fifo
  import gbt_pkg::*;
#(
  parameter int W     = 43,
  parameter int DEPTH = 32
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0]             wp;
    logic [AW:0]             rp;
  } gbt_fifo_st_t;

  gbt_fifo_st_t s_r;
  gbt_fifo_st_t s_nxt;

  // Full when pointers meet with opposite wrap bits
  assign in_ready  = !((s_r.wp[AW-1:0] == s_r.rp[AW-1:0]) && (s_r.wp[AW] != s_r.rp[AW]));
  assign out_valid = (s_r.wp != s_r.rp);
  assign out_data  = s_r.mem[s_r.rp[AW-1:0]];

  always_comb begin
    s_nxt = s_r;
    if (in_valid && in_ready) begin
      s_nxt.mem[s_r.wp[AW-1:0]] = in_data;
      s_nxt.wp = s_r.wp + 1'b1;
    end
    if (out_valid && out_ready) begin
      s_nxt.rp = s_r.rp + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule : gbt_fifo

// ===== test/gbt_burst_dp_chk.sv
// Checker of read strobe framing, read burst length and write hand-off.
// Assumes one CLK domain with synchronous active-high RESET.
`timescale 1ns/1ps
module gbt_burst_dp_chk
  import gbt_pkg::*;
(
  input wire logic                  CLK,
  input wire logic                  RESET,
  input wire logic                  DQ_OE,
  input wire logic                  READ_DATA_STROBE,
  input wire logic                  READ_DATA_STROBE_OE,
  input wire logic                  WR_VALID,
  input wire logic                  WR_READY,
  input wire logic [GBT_BANK_W-1:0] WR_BANK,
  input wire logic [GBT_COL_W-1:0]  WR_COL,
  input wire logic [GBT_DQ_W-1:0]   WR_DATA,
  input wire logic                  RD_AUTO_PRE,
  input wire logic                  WR_AUTO_PRE
);
  typedef struct packed {
    logic [7:0] tog;
    logic       stb;
    logic       oe;
  } gbt_chk_st_t;
  gbt_chk_st_t st_r;
  gbt_chk_st_t st_nxt;

  // Strobe toggles within one stretch of driven data
  always_comb begin
    st_nxt     = st_r;
    st_nxt.stb = READ_DATA_STROBE;
    st_nxt.oe  = DQ_OE;
    if (!DQ_OE) begin
      st_nxt.tog = 8'h0;
    end else if (st_r.oe && (READ_DATA_STROBE != st_r.stb)) begin
      st_nxt.tog = st_r.tog + 8'h1;
    end
  end
  always_ff @(posedge CLK) begin
    if (RESET) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  AST_OE_WITH_STROBE: assert property (DQ_OE |-> READ_DATA_STROBE_OE)
    else $error("data driven without strobe");
  AST_PRE_HIGH: assert property ($rose(READ_DATA_STROBE_OE) |-> READ_DATA_STROBE && !DQ_OE)
    else $error("strobe not high at start");
  AST_PRE_LOW: assert property ($rose(READ_DATA_STROBE_OE) |=> READ_DATA_STROBE[*2] ##[1:5] (!READ_DATA_STROBE && !DQ_OE))
    else $error("no low preamble half");
  AST_FIRST_RISE: assert property ($rose(DQ_OE) |-> READ_DATA_STROBE && !$past(READ_DATA_STROBE) && $past(READ_DATA_STROBE_OE))
    else $error("first element not on strobe rise");
  AST_BURST_COUNT: assert property ($fell(DQ_OE) |-> st_r.tog[1:0] == 2'h3)
    else $error("element count not whole bursts");
  AST_POSTAMBLE: assert property ($fell(DQ_OE) |-> READ_DATA_STROBE_OE && READ_DATA_STROBE
    ##[1:8] (!READ_DATA_STROBE_OE || DQ_OE))
    else $error("postamble wrong");
  AST_ELEM_HOLD: assert property (DQ_OE && $changed(READ_DATA_STROBE) |=> $stable(READ_DATA_STROBE)[*3])
    else $error("element shorter than half clock");
  AST_WR_HOLD: assert property (WR_VALID && !WR_READY |=> WR_VALID && $stable({WR_BANK, WR_COL, WR_DATA}))
    else $error("write element lost while stalled");
  AST_RD_AP: assert property (RD_AUTO_PRE |-> ($past(DQ_OE) || $past(DQ_OE, 2)) ##1 !RD_AUTO_PRE)
    else $error("read auto precharge misplaced");
  AST_WR_AP_PULSE: assert property (WR_AUTO_PRE |=> !WR_AUTO_PRE)
    else $error("write auto precharge too long");
  AST_RESET_QUIET: assert property ($fell(RESET) |-> !DQ_OE && !READ_DATA_STROBE_OE && !WR_VALID)
    else $error("outputs active after reset");

  cover property ($fell(DQ_OE));
  cover property (RD_AUTO_PRE);
  cover property (WR_AUTO_PRE);
  cover property (WR_VALID && !WR_READY ##1 WR_VALID);
endmodule : gbt_burst_dp_chk

bind gbt_burst_dp gbt_burst_dp_chk gbt_burst_dp_chk_inst (.CLK(CLK), .RESET(RESET), .DQ_OE(DQ_OE),
  .READ_DATA_STROBE(READ_DATA_STROBE), .READ_DATA_STROBE_OE(READ_DATA_STROBE_OE), .WR_VALID(WR_VALID),
  .WR_READY(WR_READY), .WR_BANK(WR_BANK), .WR_COL(WR_COL), .WR_DATA(WR_DATA), .RD_AUTO_PRE(RD_AUTO_PRE),
  .WR_AUTO_PRE(WR_AUTO_PRE));

// ===== test/gbt_ctrl_model.sv
// Memory controller model: free-running CK, command pins, write strobe and data.
// Assumes commands are taken on CK rise; pins change just after CK fall.
`timescale 1ns/1ps
module gbt_ctrl_model
  import gbt_pkg::*;
(
  output logic                  ck,
  output logic [GBT_CMD_W-1:0]  cmd,
  output logic [GBT_BANK_W-1:0] ba,
  output logic [GBT_ADDR_W-1:0] addr,
  output logic [GBT_DQ_W-1:0]   dq,
  output logic                  write_data_strobe
);
  int          hc = 0;
  int          skew_ns = 2;
  logic [32:0] slot [int];

  initial begin
    ck   = 1'b0;
    cmd  = 4'hf;
    ba   = 3'h0;
    addr = 9'h0;
    dq   = 32'h0;
    write_data_strobe = 1'b1;
    #3.3;
    forever begin
      #16 ck = ~ck;
      hc++;
      if (slot.exists(hc)) begin
        dq = slot[hc][31:0];
        write_data_strobe <= #(skew_ns) slot[hc][32];
        slot.delete(hc);
      end else begin
        dq = ~dq;
        write_data_strobe <= #(skew_ns) 1'b1;
      end
    end
  end

  task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [8:0] a, input int wl,
                       input logic [127:0] d);
    @(negedge ck);
    #1;
    cmd  = c;
    ba   = b;
    addr = a;
    if (c == 4'h4) begin
      if (!slot.exists(hc + 2 * wl)) slot[hc + 2 * wl] = 33'h0;
      for (int k = 0; k < 4; k++) slot[hc + 2 * wl + 1 + k] = {~k[0], d[32 * k +: 32]};
    end
    @(negedge ck);
    #1;
    cmd = 4'hf;
  endtask : issue

  // Strobe edges with no write command behind them
  task automatic stray();
    for (int k = 1; k < 6; k++) slot[hc + 4 + k] = {k[0], 32'h5a5a5a5a};
  endtask : stray
endmodule : gbt_ctrl_model

// ===== test/test_gbt_burst_dp.sv
// Bench of the burst data path: reads, writes, stray strobes, FIFO fill.
// Assumes gbt_ctrl_model on the pins and an array model in this module.
`timescale 1ns/1ps
module test_gbt_burst_dp;
  import gbt_pkg::*;
  logic                  clk = 1'b0, rst = 1'b1, ck, write_data_strobe, dq_oe, rd_stb, rd_stb_oe, wr_valid, rd_ap, wr_ap, arr_en;
  logic                  wr_drop, wr_refused, ilv = 1'b0, wr_ready = 1'b0, hold_ready = 1'b0, prev_s, prev_oe;
  logic [GBT_CMD_W-1:0]  cmd;
  logic [GBT_BANK_W-1:0] ba, arr_bank, wr_bank, rd_pre_bank, wr_pre_bank, last_rap, last_wap;
  logic [GBT_ADDR_W-1:0] addr;
  logic [GBT_COL_W-1:0]  arr_col, wr_col;
  logic [GBT_DQ_W-1:0]   dq_in, dq_out, wr_data;
  logic [GBT_LAT_W-1:0]  cas_lat = 4'h2, wr_lat = 4'h1;
  logic [63:0]           rd_seen[$], rd_exp[$], wr_seen[$], wr_exp[$];
  int                    miscompares = 0, tests_run = 0, n_ref = 0, n_drop = 0, n_rap = 0, n_wap = 0, n_fetch = 0;

  gbt_ctrl_model gbt_ctrl_model_inst (.ck(ck), .cmd(cmd), .ba(ba), .addr(addr), .dq(dq_in), .write_data_strobe(write_data_strobe));
  gbt_burst_dp #(.LAT_DEPTH(16), .FIFO_DEPTH(32)) gbt_burst_dp_inst (.CLK(clk), .RESET(rst), .CK(ck),
    .CS_N(cmd[3]), .RAS_N(cmd[2]), .CAS_N(cmd[1]), .WE_N(cmd[0]), .BA(ba), .ADDR(addr), .DQ_IN(dq_in),
    .DQ_OUT(dq_out), .DQ_OE(dq_oe), .WRITE_DATA_STROBE(write_data_strobe), .READ_DATA_STROBE(rd_stb),
    .READ_DATA_STROBE_OE(rd_stb_oe), .CAS_LATENCY(cas_lat), .WRITE_LATENCY(wr_lat), .BURST_INTERLEAVE(ilv),
    .ARR_RD_EN(arr_en), .ARR_RD_BANK(arr_bank), .ARR_RD_COL(arr_col), .ARR_RD_DATA(word_at(arr_bank, arr_col)),
    .WR_VALID(wr_valid), .WR_READY(wr_ready), .WR_BANK(wr_bank), .WR_COL(wr_col), .WR_DATA(wr_data),
    .RD_AUTO_PRE(rd_ap), .RD_PRE_BANK(rd_pre_bank), .WR_AUTO_PRE(wr_ap), .WR_PRE_BANK(wr_pre_bank),
    .WR_DROP(wr_drop), .WR_REFUSED(wr_refused));

  function automatic logic [31:0] word_at(input logic [2:0] b, input logic [7:0] c);
    return {c, 5'h0, b, c ^ 8'h5a, ~c};
  endfunction : word_at
  function automatic logic [7:0] col_at(input logic [7:0] c, input int k);
    return ilv ? {c[7:2], c[1:0] ^ 2'(k)} : {c[7:2], 2'(c[1:0] + 2'(k))};
  endfunction : col_at

  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) wr_ready <= #1 hold_ready ? 1'b0 : 1'($urandom);

  always @(posedge clk) begin
    if (dq_oe === 1'b1 && (prev_oe !== 1'b1 || rd_stb !== prev_s)) rd_seen.push_back(64'(dq_out));
    if (wr_valid === 1'b1 && wr_ready === 1'b1) wr_seen.push_back(64'({wr_bank, wr_col, wr_data}));
    if (rd_ap === 1'b1) begin
      n_rap++;
      last_rap = rd_pre_bank;
    end
    if (wr_ap === 1'b1) begin
      n_wap++;
      last_wap = wr_pre_bank;
    end
    n_ref  += int'(wr_refused === 1'b1);
    n_drop += int'(wr_drop === 1'b1);
    n_fetch += int'(arr_en === 1'b1);
    prev_s  = rd_stb;
    prev_oe = dq_oe;
  end

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic check_q(input string what, ref logic [63:0] s[$], ref logic [63:0] e[$]);
    check(what, 64'(s.size()), 64'(e.size()));
    foreach (e[i]) check(what, s[i], e[i]);
    s.delete();
    e.delete();
  endtask : check_q
  task automatic idle(input int n);
    repeat (n) @(posedge ck);
  endtask : idle
  task automatic rd(input logic [2:0] b, input logic [7:0] c, input logic ap);
    for (int k = 0; k < 4; k++) rd_exp.push_back(64'(word_at(b, col_at(c, k))));
    gbt_ctrl_model_inst.issue(4'h5, b, {ap, c}, 0, 128'h0);
  endtask : rd
  task automatic wr(input logic [2:0] b, input logic [7:0] c, input logic ap);
    logic [127:0] d;
    d = {$urandom, $urandom, $urandom, $urandom};
    for (int k = 0; k < 4; k++) wr_exp.push_back(64'({b, col_at(c, k), d[32 * k +: 32]}));
    gbt_ctrl_model_inst.issue(4'h4, b, {ap, c}, int'(wr_lat), d);
  endtask : wr
  task automatic stop_test();
    if (miscompares == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  initial begin
    #100000;
    miscompares++;
    stop_test();
  end

  initial begin
    logic [2:0] b;
    logic [7:0] c;
    void'($urandom(32'h0b78));
    repeat (10) @(posedge clk);
    rst <= #1 1'b0;
    for (int p = 0; p < 4; p++) begin
      @(posedge clk);
      ilv     <= #1 p[0];
      cas_lat <= #1 p[1] ? 4'h5 : 4'h2;
      wr_lat  <= #1 p[1] ? 4'h3 : 4'h1;
      gbt_ctrl_model_inst.skew_ns = p[1] ? 7 : 2;
      idle(2);
      b = 3'($urandom);
      c = 8'($urandom);
      rd(b, c, 1'b1);
      idle(12);
      check("read precharge", 64'({n_rap[7:0], last_rap}), 64'({8'(p + 1), b}));
      rd(b ^ 3'h1, c + 8'h1, 1'b0);
      rd(b ^ 3'h6, ~c, 1'b0);
      gbt_ctrl_model_inst.issue(4'h2, b ^ 3'h6, 9'h0, 0, 128'h0);
      idle(14);
      check_q("read data", rd_seen, rd_exp);
      check("array fetches", 64'(n_fetch), 64'(12 * (p + 1)));
      wr(b, c, 1'b1);
      idle(10);
      check("write precharge", 64'({n_wap[7:0], last_wap}), 64'({8'(p + 1), b}));
      wr(b ^ 3'h2, c ^ 8'h3, 1'b0);
      wr(b ^ 3'h4, c + 8'h7, 1'b0);
      gbt_ctrl_model_inst.issue(4'h3, b ^ 3'h1, 9'h0, 0, 128'h0);
      idle(16);
      gbt_ctrl_model_inst.stray();
      idle(8);
      check_q("write data", wr_seen, wr_exp);
    end
    hold_ready = 1'b1;
    for (int i = 0; i < 8; i++) wr(3'(i), 8'(i * 4), 1'b0);
    idle(10);
    wr(3'h7, 8'h80, 1'b0);
    idle(10);
    repeat (4) wr_exp.pop_back();
    check("refused and dropped", 64'({n_ref, n_drop}), 64'({32'd1, 32'd0}));
    hold_ready = 1'b0;
    idle(20);
    check_q("fifo data", wr_seen, wr_exp);
    stop_test();
  end
endmodule : test_gbt_burst_dp
